// [inc/das_pkg.sv]
// constants and types shared by the drive auxiliary supervisor
package das_pkg;
   // register offsets (byte addresses)
   localparam logic [7:0] OFS_FAN_MODE   = 8'h00;
   localparam logic [7:0] OFS_FAN_DELAY  = 8'h04;
   localparam logic [7:0] OFS_DROOP      = 8'h08;
   localparam logic [7:0] OFS_ZERO_THR   = 8'h0C;
   localparam logic [7:0] OFS_BELOW_ACT  = 8'h10;
   localparam logic [7:0] OFS_RS_ENABLE  = 8'h14;
   localparam logic [7:0] OFS_RS_WAIT    = 8'h18;
   localparam logic [7:0] OFS_STATUS     = 8'h1C;
   // reset values and upper limits of the settings
   localparam logic [1:0]  RST_FAN_MODE  = 2'h0;
   localparam logic [1:0]  MAX_FAN_MODE  = 2'h2;
   localparam logic [12:0] RST_FAN_DELAY = 13'h012C;   // 30.0 s in 0.1 s
   localparam logic [12:0] MAX_FAN_DELAY = 13'h1770;   // 600.0 s
   localparam logic [9:0]  RST_DROOP     = 10'h000;    // 0.00 Hz in 0.01 Hz
   localparam logic [9:0]  MAX_DROOP     = 10'h3E8;    // 10.00 Hz
   localparam logic [15:0] RST_ZERO_THR  = 16'h0064;   // 1.00 Hz
   localparam logic [1:0]  RST_BELOW_ACT = 2'h0;
   localparam logic        RST_RS_ENABLE = 1'b0;
   localparam logic [9:0]  RST_RS_WAIT   = 10'h0C8;    // 2.00 s in 0.01 s
   localparam logic [9:0]  MAX_RS_WAIT   = 10'h3E8;    // 10.00 s
   // below-threshold actions
   localparam logic [1:0]  ACT_FOLLOW    = 2'h0;
   localparam logic [1:0]  ACT_STOP      = 2'h1;
   localparam logic [1:0]  ACT_THRESHOLD = 2'h2;
   localparam logic [1:0]  ACT_ZERO      = 2'h3;
   // fan modes
   localparam logic [1:0]  FAN_AUTO      = 2'h0;
   localparam logic [1:0]  FAN_IMMED     = 2'h1;
   localparam logic [1:0]  FAN_ALWAYS    = 2'h2;
   // timing: one base tick of 10 ms
   localparam int          CLK_MHZ       = 200;
   localparam int          TICK_TIME_US  = 10000;
   localparam int          TICK_CYCLES   = TICK_TIME_US * CLK_MHZ;
   localparam logic [15:0] FAN_TICKS_PER_UNIT = 16'h000A;  // 0.1 s = 10 ticks
   localparam int          PRE_W         = 24;
   localparam int          LOAD_SHIFT    = 8;

   typedef enum logic [1:0] {RS_IDLE, RS_LOST, RS_WAIT} das_rs_e;

   typedef struct packed {
      logic [1:0]       fanMode;
      logic [12:0]      fanDelay;
      logic [9:0]       droop;
      logic [15:0]      zeroThr;
      logic [1:0]       belowAct;
      logic             rsEn;
      logic [9:0]       rsWait;
      logic [31:0]      rdata;
      logic [PRE_W-1:0] preCnt;
      logic             tick;
      logic             fanHold;
      logic             fanOn;
      logic             outEn;
      logic [15:0]      outFreq;
      das_rs_e          rsState;
      logic             restartReq;
      logic             speedTrack;
   } das_state_s;

   typedef struct packed {
      logic [15:0] count;
   } das_tmr_s;
endpackage : das_pkg

// [inc/das_tmr_if.sv]
// timer control signals between the supervisor and its tick timers
`timescale 1ns/100ps
`default_nettype none
interface das_tmr_if;
   logic        clear;
   logic        tick;
   logic [15:0] limit;
   logic        done;
   modport ctrl (output clear, output tick, output limit, input done);
   modport tmr  (input clear, input tick, input limit, output done);
endinterface : das_tmr_if
`default_nettype wire

// [sim/tb.sv]
// self-checking bench for the drive auxiliary supervisor, register port and drive-state pins
`timescale 1ns/100ps
`default_nettype none
module tb;
   localparam int TICKS = 4;
   // short tick so the 0.1 s and 0.01 s counts finish in tens of cycles
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic [31:0] regWdata = 32'h0000_0000;
   logic        regWr = 1'b0;
   logic        regRd = 1'b0;
   logic [31:0] regRdata;
   logic        driveRunning = 1'b0;
   logic        overTemp = 1'b0;
   logic        twoWireMode = 1'b0;
   logic        runTerminal = 1'b0;
   logic        powerOk = 1'b1;
   logic [15:0] setFreq = 16'h0000;
   logic [15:0] upperLimit = 16'h1388;
   logic [7:0]  loadLevel = 8'h00;
   logic        fanOn;
   logic        outEnable;
   logic [15:0] outFreq;
   logic        restartReq;
   logic        speedTrack;
   int          miscompares = 0;
   int          comparisons = 0;
   int          cnt;
   logic [1:0]  actTab [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
   logic [15:0] frqTab [4] = '{16'h0032, 16'h0000, 16'h0064, 16'h0000};
   logic        enTab  [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

   always #2.5 clk = ~clk;

   drive_aux_supervisor #(.TICK_CYCLES(TICKS)) u_drive_aux_supervisor (
      .clk         (clk),
      .resetn      (resetn),
      .regAddr     (regAddr),
      .regWdata    (regWdata),
      .regWr       (regWr),
      .regRd       (regRd),
      .regRdata    (regRdata),
      .driveRunning(driveRunning),
      .overTemp    (overTemp),
      .twoWireMode (twoWireMode),
      .runTerminal (runTerminal),
      .powerOk     (powerOk),
      .setFreq     (setFreq),
      .upperLimit  (upperLimit),
      .loadLevel   (loadLevel),
      .fanOn       (fanOn),
      .outEnable   (outEnable),
      .outFreq     (outFreq),
      .restartReq  (restartReq),
      .speedTrack  (speedTrack)
   );

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWdata <= d;
      @(posedge clk);
      regWr    <= 1'b0;
   endtask : regWrite

   // read data stand only in the cycle after the strobe, so sample there
   task automatic regRead(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd   <= 1'b0;
      #1;
      chk(regRdata, exp);
   endtask : regRead

   task automatic print_verdict;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : print_verdict

   initial begin
      cyc(20000);
      miscompares++;
      print_verdict();
   end

   initial begin
      cyc(3);
      resetn <= 1'b1;
      cyc(3);
      chk(fanOn, 1'b0);
      regRead(das_pkg::OFS_FAN_MODE, 32'h0000_0000);
      regRead(das_pkg::OFS_FAN_DELAY, 32'h0000_012C);
      regRead(das_pkg::OFS_DROOP, 32'h0000_0000);
      regRead(das_pkg::OFS_ZERO_THR, 32'h0000_0064);
      regRead(das_pkg::OFS_BELOW_ACT, 32'h0000_0000);
      regRead(das_pkg::OFS_RS_ENABLE, 32'h0000_0000);
      regRead(das_pkg::OFS_RS_WAIT, 32'h0000_00C8);
      regRead(8'h20, 32'h0000_0000);
      // out-of-range writes leave the setting untouched
      regWrite(das_pkg::OFS_FAN_MODE, 32'h0000_0003);
      regRead(das_pkg::OFS_FAN_MODE, 32'h0000_0000);
      regWrite(das_pkg::OFS_FAN_DELAY, 32'h0000_1771);
      regRead(das_pkg::OFS_FAN_DELAY, 32'h0000_012C);
      regWrite(das_pkg::OFS_FAN_DELAY, 32'h0000_1770);
      regRead(das_pkg::OFS_FAN_DELAY, 32'h0000_1770);
      regWrite(das_pkg::OFS_DROOP, 32'h0000_03E9);
      regRead(das_pkg::OFS_DROOP, 32'h0000_0000);
      regWrite(das_pkg::OFS_DROOP, 32'h0000_03E8);
      regRead(das_pkg::OFS_DROOP, 32'h0000_03E8);
      regWrite(das_pkg::OFS_ZERO_THR, 32'h0000_1389);
      regRead(das_pkg::OFS_ZERO_THR, 32'h0000_0064);
      regWrite(das_pkg::OFS_ZERO_THR, 32'h0000_1388);
      regRead(das_pkg::OFS_ZERO_THR, 32'h0000_1388);
      regWrite(das_pkg::OFS_ZERO_THR, 32'h0000_0064);
      regWrite(das_pkg::OFS_RS_WAIT, 32'h0000_03E9);
      regRead(das_pkg::OFS_RS_WAIT, 32'h0000_00C8);
      regWrite(das_pkg::OFS_DROOP, 32'h0000_0000);
      // fan mode 2 runs with the drive stopped
      regWrite(das_pkg::OFS_FAN_MODE, 32'h0000_0002);
      cyc(3);
      chk(fanOn, 1'b1);
      // status: fan on, never held, output enabled, restart idle
      regRead(das_pkg::OFS_STATUS, 32'h0000_0005);
      // fan mode 1 stops with the drive, over-temperature overrides
      regWrite(das_pkg::OFS_FAN_MODE, 32'h0000_0001);
      driveRunning <= 1'b1;
      cyc(3);
      chk(fanOn, 1'b1);
      driveRunning <= 1'b0;
      cyc(3);
      chk(fanOn, 1'b0);
      overTemp <= 1'b1;
      cyc(3);
      chk(fanOn, 1'b1);
      overTemp <= 1'b0;
      cyc(3);
      chk(fanOn, 1'b0);
      // mode 0 with 0.1 s delay: about 10 ticks of TICKS cycles
      regWrite(das_pkg::OFS_FAN_MODE, 32'h0000_0000);
      regWrite(das_pkg::OFS_FAN_DELAY, 32'h0000_0001);
      driveRunning <= 1'b1;
      cyc(3);
      driveRunning <= 1'b0;
      cyc(30);
      chk(fanOn, 1'b1);
      cyc(30);
      chk(fanOn, 1'b0);
      // every below-threshold action with setFreq 0.50 Hz, threshold 1.00 Hz
      setFreq <= 16'h0032;
      for (int i = 0; i < 4; i++) begin
         regWrite(das_pkg::OFS_BELOW_ACT, {30'h000_0000, actTab[i]});
         cyc(3);
         chk(outFreq, frqTab[i]);
         chk(outEnable, enTab[i]);
      end
      // droop 1.00 Hz at half load takes 0.50 Hz off 10.00 Hz
      regWrite(das_pkg::OFS_BELOW_ACT, 32'h0000_0000);
      regWrite(das_pkg::OFS_DROOP, 32'h0000_0064);
      setFreq   <= 16'h03E8;
      loadLevel <= 8'h80;
      cyc(3);
      chk(outFreq, 16'h03B6);
      // power loss with restart disabled never restarts
      twoWireMode  <= 1'b1;
      driveRunning <= 1'b1;
      runTerminal  <= 1'b1;
      cyc(2);
      powerOk <= 1'b0;
      cyc(3);
      powerOk <= 1'b1;
      cnt = 0;
      repeat (120) begin
         cyc(1);
         if (restartReq !== 1'b0) cnt++;
      end
      chk(cnt, 0);
      // enabled, 0.10 s wait: pulse about 10 ticks after power returns
      regWrite(das_pkg::OFS_RS_ENABLE, 32'h0000_0001);
      regWrite(das_pkg::OFS_RS_WAIT, 32'h0000_000A);
      cyc(2);
      powerOk <= 1'b0;
      cyc(3);
      powerOk <= 1'b1;
      cnt = 0;
      while (restartReq !== 1'b1 && cnt < 200) begin
         cyc(1);
         cnt++;
      end
      chk(cnt >= 30 && cnt <= 50, 1'b1);
      chk(speedTrack, 1'b1);
      cyc(1);
      chk(restartReq, 1'b0);
      chk(speedTrack, 1'b0);
      print_verdict();
   end
endmodule : tb
`default_nettype wire

// [verilog/das_tick_timer.sv]
// tick counter that reports when a programmed number of ticks has elapsed
`timescale 1ns/100ps
`default_nettype none
module das_tick_timer (
   // clock and reset
   input  wire logic  clk,
   input  wire logic  rstn,
   // control
   das_tmr_if.tmr     tmr
);
   das_pkg::das_tmr_s state_reg;
   das_pkg::das_tmr_s state_next;

   always_comb begin
      state_next = state_reg;
      if (tmr.clear) begin
         state_next.count = 16'h0000;
      end else if (tmr.tick && (state_reg.count < tmr.limit)) begin
         state_next.count = state_reg.count + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // a zero limit is done at once, so a zero delay acts on the next edge
   assign tmr.done = (state_reg.count >= tmr.limit);
endmodule : das_tick_timer
`default_nettype wire

// [verilog/das_unused_placeholder_none.sv]
// intentionally minimal: no further modules
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [verilog/drive_aux_supervisor.sv]
// drive auxiliary supervisor: fan sequencing, droop, zero frequency, power-fail restart
//
// Contract
// - fan mode setting holds 0 to 2, resets to 0.
// - fan off-delay setting 0.0 to 600.0 s, default 30.0 s.
// - over-temperature keeps the fan running in every fan mode.
// - mode 0: fan runs with drive, stops after off-delay once stopped.
// - mode 2: fan runs continuously from power-on.
// - droop 0.00 to 10.00 Hz, default 0; lowers frequency under heavy load.
// - zero threshold 0.00 to upper limit, default 1.00 Hz.
// - below threshold: follow, stay stopped, run at threshold, or run at zero.
// - power-fail restart enable 0 or 1, default 0.
// - two-wire, run terminal held at power return: wait, restart with tracking.
// - restart wait setting 0.00 to 10.00 s, default 2.00 s.
`timescale 1ns/100ps
`default_nettype none
module drive_aux_supervisor #(
   parameter int TICK_CYCLES = das_pkg::TICK_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWdata,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdata,
   // drive state
   input  wire logic        driveRunning,
   input  wire logic        overTemp,
   input  wire logic        twoWireMode,
   input  wire logic        runTerminal,
   input  wire logic        powerOk,
   input  wire logic [15:0] setFreq,
   input  wire logic [15:0] upperLimit,
   input  wire logic [7:0]  loadLevel,
   // outputs to the drive
   output logic             fanOn,
   output logic             outEnable,
   output logic      [15:0] outFreq,
   output logic             restartReq,
   output logic             speedTrack
);
   localparam logic [das_pkg::PRE_W-1:0] TICK_LAST = das_pkg::PRE_W'(TICK_CYCLES - 1);

   logic                rstSync1;
   logic                rstSync2;
   das_pkg::das_state_s state_reg;
   das_pkg::das_state_s state_next;
   logic [17:0]         dropWide;
   logic [15:0]         dropAmt;
   logic [15:0]         baseFreq;
   logic                baseEn;

   das_tmr_if fanTmr ();
   das_tmr_if rsTmr ();

   // reset is released through two flops so every state flop leaves reset together
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end

   das_tick_timer u_fan_timer (
      .clk  (clk),
      .rstn (rstSync2),
      .tmr  (fanTmr.tmr)
   );

   das_tick_timer u_rs_timer (
      .clk  (clk),
      .rstn (rstSync2),
      .tmr  (rsTmr.tmr)
   );

   // off-delay counts only while stopped and cool with the fan still held on
   assign fanTmr.tick  = state_reg.tick;
   assign fanTmr.clear = driveRunning || overTemp || !state_reg.fanHold;
   assign fanTmr.limit = 16'(state_reg.fanDelay) * das_pkg::FAN_TICKS_PER_UNIT;
   assign rsTmr.tick   = state_reg.tick;
   assign rsTmr.clear  = (state_reg.rsState != das_pkg::RS_WAIT);
   assign rsTmr.limit  = 16'(state_reg.rsWait);

   // droop scales with load; full scale load 0xFF gives 255/256 of the droop amount
   assign dropWide = 18'(state_reg.droop) * 18'(loadLevel);
   assign dropAmt  = 16'(dropWide >> das_pkg::LOAD_SHIFT);

   always_comb begin
      baseFreq = setFreq;
      baseEn   = 1'b1;
      if (setFreq < state_reg.zeroThr) begin
         case (state_reg.belowAct)
            das_pkg::ACT_STOP: begin
               baseFreq = 16'h0000;
               baseEn   = 1'b0;
            end
            das_pkg::ACT_THRESHOLD: begin
               baseFreq = state_reg.zeroThr;
            end
            das_pkg::ACT_ZERO: begin
               baseFreq = 16'h0000;
            end
            default: begin
               baseFreq = setFreq;
            end
         endcase
      end
   end

   always_comb begin
      state_next            = state_reg;
      state_next.restartReq = 1'b0;
      state_next.speedTrack = 1'b0;
      state_next.rdata      = 32'h0000_0000;
      // base tick prescaler
      if (state_reg.preCnt >= TICK_LAST) begin
         state_next.preCnt = '0;
         state_next.tick   = 1'b1;
      end else begin
         state_next.preCnt = state_reg.preCnt + 1'b1;
         state_next.tick   = 1'b0;
      end
      // register writes; out-of-range values are ignored, but below-action and restart enable just take their low bits
      if (regWr) begin
         if (regAddr == das_pkg::OFS_FAN_MODE) begin
            if (regWdata[1:0] <= das_pkg::MAX_FAN_MODE && regWdata[31:2] == '0) begin
               state_next.fanMode = regWdata[1:0];
            end
         end else if (regAddr == das_pkg::OFS_FAN_DELAY) begin
            if (regWdata <= 32'(das_pkg::MAX_FAN_DELAY)) begin
               state_next.fanDelay = regWdata[12:0];
            end
         end else if (regAddr == das_pkg::OFS_DROOP) begin
            if (regWdata <= 32'(das_pkg::MAX_DROOP)) begin
               state_next.droop = regWdata[9:0];
            end
         end else if (regAddr == das_pkg::OFS_ZERO_THR) begin
            if (regWdata <= 32'(upperLimit)) begin
               state_next.zeroThr = regWdata[15:0];
            end
         end else if (regAddr == das_pkg::OFS_BELOW_ACT) begin
            state_next.belowAct = regWdata[1:0];
         end else if (regAddr == das_pkg::OFS_RS_ENABLE) begin
            state_next.rsEn = regWdata[0];
         end else if (regAddr == das_pkg::OFS_RS_WAIT) begin
            if (regWdata <= 32'(das_pkg::MAX_RS_WAIT)) begin
               state_next.rsWait = regWdata[9:0];
            end
         end
      end
      // register reads, answered in the next cycle; unmapped reads return zero
      if (regRd) begin
         if (regAddr == das_pkg::OFS_FAN_MODE) begin
            state_next.rdata = 32'(state_reg.fanMode);
         end else if (regAddr == das_pkg::OFS_FAN_DELAY) begin
            state_next.rdata = 32'(state_reg.fanDelay);
         end else if (regAddr == das_pkg::OFS_DROOP) begin
            state_next.rdata = 32'(state_reg.droop);
         end else if (regAddr == das_pkg::OFS_ZERO_THR) begin
            state_next.rdata = 32'(state_reg.zeroThr);
         end else if (regAddr == das_pkg::OFS_BELOW_ACT) begin
            state_next.rdata = 32'(state_reg.belowAct);
         end else if (regAddr == das_pkg::OFS_RS_ENABLE) begin
            state_next.rdata = 32'(state_reg.rsEn);
         end else if (regAddr == das_pkg::OFS_RS_WAIT) begin
            state_next.rdata = 32'(state_reg.rsWait);
         end else if (regAddr == das_pkg::OFS_STATUS) begin
            state_next.rdata = {27'h000_0000, state_reg.rsState, state_reg.outEn,
                                state_reg.fanHold, state_reg.fanOn};
         end
      end
      // fan sequencing
      if (driveRunning) begin
         state_next.fanHold = 1'b1;
      end else if (state_reg.fanMode != das_pkg::FAN_AUTO || fanTmr.done) begin
         state_next.fanHold = 1'b0;
      end
      if (overTemp) begin
         state_next.fanOn = 1'b1;
      end else if (state_reg.fanMode == das_pkg::FAN_ALWAYS) begin
         state_next.fanOn = 1'b1;
      end else if (driveRunning) begin
         state_next.fanOn = 1'b1;
      end else if (state_reg.fanMode == das_pkg::FAN_AUTO) begin
         state_next.fanOn = state_reg.fanHold && !fanTmr.done;
      end else begin
         state_next.fanOn = 1'b0;
      end
      // frequency path: threshold action, then droop, floored at zero
      state_next.outEn = baseEn;
      if (!baseEn || dropAmt >= baseFreq) begin
         state_next.outFreq = 16'h0000;
      end else begin
         state_next.outFreq = baseFreq - dropAmt;
      end
      // power-fail restart
      case (state_reg.rsState)
         das_pkg::RS_IDLE: begin
            if (state_reg.rsEn && twoWireMode && driveRunning && !powerOk) begin
               state_next.rsState = das_pkg::RS_LOST;
            end
         end
         das_pkg::RS_LOST: begin
            if (!state_reg.rsEn) begin
               state_next.rsState = das_pkg::RS_IDLE;
            end else if (powerOk) begin
               state_next.rsState = runTerminal ? das_pkg::RS_WAIT : das_pkg::RS_IDLE;
            end
         end
         das_pkg::RS_WAIT: begin
            // a released run terminal or a lost enable cancels the pending restart
            if (!state_reg.rsEn || !runTerminal || !twoWireMode) begin
               state_next.rsState = das_pkg::RS_IDLE;
            end else if (!powerOk) begin
               state_next.rsState = das_pkg::RS_LOST;
            end else if (rsTmr.done) begin
               state_next.rsState    = das_pkg::RS_IDLE;
               state_next.restartReq = 1'b1;
               state_next.speedTrack = 1'b1;
            end
         end
         default: begin
            state_next.rsState = das_pkg::RS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstSync2) begin
      if (!rstSync2) begin
         state_reg          <= '0;
         state_reg.fanMode  <= das_pkg::RST_FAN_MODE;
         state_reg.fanDelay <= das_pkg::RST_FAN_DELAY;
         state_reg.droop    <= das_pkg::RST_DROOP;
         state_reg.zeroThr  <= das_pkg::RST_ZERO_THR;
         state_reg.belowAct <= das_pkg::RST_BELOW_ACT;
         state_reg.rsEn     <= das_pkg::RST_RS_ENABLE;
         state_reg.rsWait   <= das_pkg::RST_RS_WAIT;
         state_reg.rsState  <= das_pkg::RS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign regRdata   = state_reg.rdata;
   assign fanOn      = state_reg.fanOn;
   assign outEnable  = state_reg.outEn;
   assign outFreq    = state_reg.outFreq;
   assign restartReq = state_reg.restartReq;
   assign speedTrack = state_reg.speedTrack;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSync2);

   sequence s_drive_stops;
      (state_reg.fanMode == das_pkg::FAN_AUTO) && !overTemp && $fell(driveRunning);
   endsequence

   sequence s_wait_elapsed;
      (state_reg.rsState == das_pkg::RS_WAIT) && rsTmr.done && runTerminal && powerOk;
   endsequence

   a_overtemp_fan: assert property (overTemp |=> fanOn)
      else $error("fan off during over-temperature");
   a_always_fan: assert property ((state_reg.fanMode == das_pkg::FAN_ALWAYS) |=> fanOn)
      else $error("fan off in continuous mode");
   a_immed_off: assert property ((state_reg.fanMode == das_pkg::FAN_IMMED) && !driveRunning
                                 && !overTemp |=> !fanOn)
      else $error("fan still on after stop in immediate mode");
   a_delay_hold: assert property (s_drive_stops ##0 (state_reg.fanDelay != 13'h0000)
                                  |=> fanOn[*2])
      else $error("fan dropped before off-delay");
   a_fan_mode_range: assert property (state_reg.fanMode <= das_pkg::MAX_FAN_MODE)
      else $error("fan mode out of range");
   a_cfg_ranges: assert property (state_reg.fanDelay <= das_pkg::MAX_FAN_DELAY
                                  && state_reg.droop <= das_pkg::MAX_DROOP
                                  && state_reg.rsWait <= das_pkg::MAX_RS_WAIT)
      else $error("setting out of range");
   a_below_stop: assert property ((setFreq < state_reg.zeroThr)
                                  && (state_reg.belowAct == das_pkg::ACT_STOP)
                                  |=> !outEnable && (outFreq == 16'h0000))
      else $error("output active below threshold in stop action");
   a_below_thr: assert property ((setFreq < state_reg.zeroThr)
                                 && (state_reg.droop == 10'h000)
                                 && (state_reg.belowAct == das_pkg::ACT_THRESHOLD)
                                 |=> outEnable && (outFreq == $past(state_reg.zeroThr)))
      else $error("output not at threshold");
   // widened to 17 bits so a set frequency near full scale cannot wrap the sum
   a_droop_bound: assert property (outEnable |->
                                   (17'(outFreq) + 17'(das_pkg::MAX_DROOP) >= 17'($past(setFreq)))
                                   || ($past(setFreq) < $past(state_reg.zeroThr)))
      else $error("droop exceeds its range");
   a_restart_off: assert property (!state_reg.rsEn |=> !restartReq)
      else $error("restart while disabled");
   a_restart_seq: assert property (s_wait_elapsed ##0 state_reg.rsEn ##0 twoWireMode
                                   |=> restartReq && speedTrack)
      else $error("restart missing after wait");
   a_restart_cause: assert property (restartReq |-> $past(runTerminal) && $past(powerOk)
                                     && !$past(restartReq))
      else $error("restart without held run terminal");
endmodule : drive_aux_supervisor
`default_nettype wire
